// [hdl/bca_pkg.sv]
// Package of constants, types and register map for the charge accumulator.
package bca_pkg;

   // ************************************************************
   // Register map (AXI4-Lite byte addresses)
   // ************************************************************
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_NAC      = 8'h08;
   localparam logic [7:0] ADDR_LMD      = 8'h0c;
   localparam logic [7:0] ADDR_VOLT     = 8'h10;
   localparam logic [7:0] ADDR_TEMP     = 8'h14;
   localparam logic [7:0] ADDR_RATE     = 8'h18;
   localparam logic [7:0] ADDR_TTE      = 8'h1c;
   localparam logic [7:0] ADDR_EDV      = 8'h20;
   localparam logic [7:0] ADDR_DEADBAND = 8'h24;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
   localparam logic [7:0] ADDR_IRQ_EN   = 8'h2c;
   localparam logic [7:0] ADDR_IRQ_CLR  = 8'h30;
   localparam logic [7:0] ADDR_ACC      = 8'h34;
   localparam logic [7:0] ADDR_TCOMP    = 8'h38;

   // ************************************************************
   // Fields and reset values
   // ************************************************************
   localparam int CTRL_LEARN_BIT   = 0;
   localparam int STAT_UNTRUST_BIT = 0;
   localparam int STAT_SLEEP_BIT   = 1;
   localparam int STAT_EDV1_BIT    = 2;
   localparam int STAT_EDVF_BIT    = 3;
   localparam int STAT_FAIL_BIT    = 4;
   localparam int IRQ_W            = 4;
   localparam int IRQ_EDV1         = 0;
   localparam int IRQ_EDVF         = 1;
   localparam int IRQ_SLEEP        = 2;
   localparam int IRQ_CORRUPT      = 3;
   localparam logic [15:0] EDV1_RST = 16'h0cb2;
   localparam logic [15:0] EDVF_RST = 16'h0bb8;
   localparam logic [7:0]  CHECK_A  = 8'h5a;
   localparam logic [7:0]  CHECK_B  = 8'ha5;
   localparam logic [1:0]  RESP_OK  = 2'b00;
   localparam logic [1:0]  RESP_ERR = 2'b10;
   // One count of capacity is 3 uVh; with Rs in milliohms that is 3/Rs mAh.
   localparam int CAP_LSB_NVH = 3000;
   localparam int DEADBAND_STEP_UV = 6;
   localparam int MIN_PER_HOUR = 60;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      ST_CHECK = 2'b00,
      ST_RUN   = 2'b01,
      ST_SLEEP = 2'b10
   } bca_state_e;

   typedef struct packed {
      logic        valid;
      logic [15:0] volt_raw;
      logic [15:0] temp_raw;
      logic [15:0] volt_off;
      logic [15:0] temp_off;
   } bca_adc_s;

   typedef struct packed {
      logic       pulse;
      logic       discharge;
      logic [7:0] magnitude;
   } bca_vfc_s;

endpackage : bca_pkg

// [hdl/bca_core.sv]
// Charge accumulator core with AXI4-Lite register access.
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module bca_core import bca_pkg::*; #(
   parameter int          ACC_W       = 16,
   parameter logic [15:0] LMD_DEFAULT = 16'h2000
) (
   input  wire logic              CLK_SYS_I,
   input  wire logic              RST_N_I,
   input  wire logic              HOST_LINE_I,
   input  wire logic              RBI_OK_I,
   input  wire logic [15:0]       BACKUP_NAC_I,
   input  wire logic [15:0]       BACKUP_LMD_I,
   input  wire logic [7:0]        BACKUP_NAC_DUP_I,
   input  wire logic [7:0]        BACKUP_LMD_DUP_I,
   input  wire logic [7:0]        BACKUP_CHK_A_I,
   input  wire logic [7:0]        BACKUP_CHK_B_I,
   input  wire logic              BACKUP_UNTRUST_I,
   input  wire bca_vfc_s          VFC_I,
   input  wire logic [7:0]        VFC_OFFSET_I,
   input  wire bca_adc_s          ADC_I,
   input  wire logic [7:0]        NV_DEADBAND_I,
   output logic [15:0]            NAC_O,
   output logic [15:0]            LMD_O,
   output logic [7:0]             NAC_DUP_O,
   output logic [7:0]             LMD_DUP_O,
   output logic                   UNTRUST_O,
   output logic                   SLEEP_O,
   output logic                   IRQ_O,
   input  wire logic [7:0]        S_AXI_AWADDR,
   input  wire logic              S_AXI_AWVALID,
   output logic                   S_AXI_AWREADY,
   input  wire logic [31:0]       S_AXI_WDATA,
   input  wire logic [3:0]        S_AXI_WSTRB,
   input  wire logic              S_AXI_WVALID,
   output logic                   S_AXI_WREADY,
   output logic [1:0]             S_AXI_BRESP,
   output logic                   S_AXI_BVALID,
   input  wire logic              S_AXI_BREADY,
   input  wire logic [7:0]        S_AXI_ARADDR,
   input  wire logic              S_AXI_ARVALID,
   output logic                   S_AXI_ARREADY,
   output logic [31:0]            S_AXI_RDATA,
   output logic [1:0]             S_AXI_RRESP,
   output logic                   S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY
);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   // The host line and the backup sense are asynchronous pins.
   logic [1:0] host_sync_reg, host_sync_next;
   logic [1:0] rbi_sync_reg,  rbi_sync_next;
   always_comb begin
      host_sync_next = {host_sync_reg[0], HOST_LINE_I};
      rbi_sync_next  = {rbi_sync_reg[0], RBI_OK_I};
   end
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         host_sync_reg <= 2'b11;
         // The backup sense keeps sampling in reset so the check sees a settled level.
         rbi_sync_reg  <= rbi_sync_next;
      end else begin
         host_sync_reg <= host_sync_next;
         rbi_sync_reg  <= rbi_sync_next;
      end
   end
   logic host_high;
   logic rbi_ok;
   assign host_high = host_sync_reg[1];
   assign rbi_ok    = rbi_sync_reg[1];

   // ************************************************************
   // Gauge state
   // ************************************************************
   bca_state_e         state_reg, state_next;
   logic [15:0]        nac_reg, nac_next;
   logic [15:0]        lmd_reg, lmd_next;
   logic               untrust_reg, untrust_next;
   logic               fail_reg, fail_next;
   logic [ACC_W-1:0]   acc_reg, acc_next;
   logic [15:0]        volt_reg, volt_next;
   logic [15:0]        temp_reg, temp_next;
   logic [15:0]        rate_reg, rate_next;
   logic [15:0]        tte_reg, tte_next;
   logic [15:0]        edv1_reg, edv1_next;
   logic [15:0]        edvf_reg, edvf_next;
   logic [7:0]         deadband_reg, deadband_next;
   logic [7:0]         tcomp_reg, tcomp_next;
   logic [IRQ_W-1:0]   irq_stat_reg, irq_stat_next;
   logic [IRQ_W-1:0]   irq_en_reg, irq_en_next;
   logic               edv1_hit, edvf_hit, learn_done;
   logic [IRQ_W-1:0]   irq_set, irq_clr;
   logic               wr_fire;
   logic [7:0]         wr_addr;
   logic [31:0]        wr_data;
   logic [ACC_W:0]     acc_wide;
   logic [8:0]         mag_corr;
   logic [15:0]        volt_corr;
   logic [31:0]        tte_full;

   always_comb begin
      state_next    = state_reg;
      nac_next      = nac_reg;
      lmd_next      = lmd_reg;
      untrust_next  = untrust_reg;
      fail_next     = fail_reg;
      acc_next      = acc_reg;
      volt_next     = volt_reg;
      temp_next     = temp_reg;
      rate_next     = rate_reg;
      tte_next      = tte_reg;
      edv1_next     = edv1_reg;
      edvf_next     = edvf_reg;
      deadband_next = deadband_reg;
      tcomp_next    = tcomp_reg;
      irq_en_next   = irq_en_reg;
      irq_set       = '0;
      irq_clr       = '0;
      learn_done    = 1'b0;
      acc_wide      = '0;
      // Offset removal on the converter magnitude; negative results read as zero.
      mag_corr  = {1'b0, VFC_I.magnitude} - {1'b0, VFC_OFFSET_I};
      if (mag_corr[8]) begin
         mag_corr = '0;
      end
      volt_corr = ADC_I.volt_raw - ADC_I.volt_off;
      edv1_hit  = (volt_reg <= edv1_reg);
      edvf_hit  = (volt_reg <= edvf_reg);
      // Capacity over a per-hour rate gives hours; times MIN_PER_HOUR gives minutes remaining.
      tte_full = (rate_reg == 16'h0000) ? 32'hffff_ffff
               : ({16'h0000, nac_reg} * 32'(MIN_PER_HOUR)) / {16'h0000, rate_reg};
      unique case (state_reg)
         ST_CHECK: begin
            // Backup comparison runs once after every reset.
            if ((BACKUP_NAC_DUP_I == BACKUP_NAC_I[15:8])
                && (BACKUP_LMD_DUP_I == BACKUP_LMD_I[15:8])
                && (BACKUP_CHK_A_I == CHECK_A) && (BACKUP_CHK_B_I == CHECK_B)
                && rbi_ok) begin
               nac_next     = BACKUP_NAC_I;
               lmd_next     = BACKUP_LMD_I;
               untrust_next = BACKUP_UNTRUST_I;
               acc_next     = ACC_W'(BACKUP_NAC_I);
            end else begin
               nac_next     = '0;
               lmd_next     = LMD_DEFAULT;
               untrust_next = 1'b1;
               fail_next    = 1'b1;
               irq_set[IRQ_CORRUPT] = 1'b1;
            end
            deadband_next = NV_DEADBAND_I;
            state_next = ST_RUN;
         end
         ST_RUN: begin
            if (!host_high) begin
               state_next = ST_SLEEP;
               irq_set[IRQ_SLEEP] = 1'b1;
            end
            // Below the deadband the pulse is dropped so idle offset never drifts NOMINAL_REMAINING_CAPACITY.
            if (VFC_I.pulse && ((deadband_reg == 8'h00)
                || (mag_corr >= {1'b0, deadband_reg}))) begin
               if (VFC_I.discharge) begin
                  acc_wide = {1'b0, acc_reg} - (ACC_W+1)'(mag_corr);
                  acc_next = acc_wide[ACC_W] ? '0 : acc_wide[ACC_W-1:0];
               end else begin
                  acc_wide = {1'b0, acc_reg} + (ACC_W+1)'(mag_corr);
                  acc_next = acc_wide[ACC_W] ? '1 : acc_wide[ACC_W-1:0];
               end
               // NAC is LMD when the accumulator exceeds LMD, else the accumulator shifted right by tcomp_reg[2:0] for temperature compensation.
               nac_next = (acc_next > ACC_W'(lmd_reg)) ? lmd_reg
                        : 16'(acc_next >> tcomp_reg[2:0]);
            end
            if (ADC_I.valid) begin
               volt_next = volt_corr;
               temp_next = ADC_I.temp_raw - ADC_I.temp_off;
            end
            // Interrupt thresholds act on fresh samples only; the status flags still compare the zero left by reset.
            if (ADC_I.valid && (volt_corr <= edv1_reg)) begin
               irq_set[IRQ_EDV1] = 1'b1;
            end
            if (ADC_I.valid && (volt_corr <= edvf_reg)) begin
               irq_set[IRQ_EDVF] = 1'b1;
               acc_next = '0;
               nac_next = '0;
            end
         end
         ST_SLEEP: begin
            if (host_high) begin
               state_next = ST_RUN;
            end
         end
      endcase
      tte_next = (tte_full[31:16] != 16'h0000) ? 16'hffff : tte_full[15:0];
      if (wr_fire) begin
         unique case (wr_addr)
            ADDR_CTRL:     learn_done    = wr_data[CTRL_LEARN_BIT];
            ADDR_RATE:     rate_next     = wr_data[15:0];
            ADDR_EDV:      {edv1_next, edvf_next} = wr_data;
            ADDR_DEADBAND: deadband_next = wr_data[7:0];
            ADDR_TCOMP:    tcomp_next    = wr_data[7:0];
            ADDR_IRQ_EN:   irq_en_next   = wr_data[IRQ_W-1:0];
            ADDR_IRQ_CLR:  irq_clr       = wr_data[IRQ_W-1:0];
            default:       learn_done    = 1'b0;
         endcase
      end
      if (learn_done && edv1_hit) begin
         untrust_next = 1'b0;
      end
      // A new event in the clearing cycle wins over the clear.
      irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         state_reg    <= ST_CHECK;
         nac_reg      <= '0;
         lmd_reg      <= '0;
         untrust_reg  <= 1'b1;
         fail_reg     <= 1'b0;
         acc_reg      <= '0;
         volt_reg     <= '0;
         temp_reg     <= '0;
         rate_reg     <= '0;
         tte_reg      <= '0;
         edv1_reg     <= EDV1_RST;
         edvf_reg     <= EDVF_RST;
         deadband_reg <= '0;
         tcomp_reg    <= '0;
         irq_stat_reg <= '0;
         irq_en_reg   <= '0;
      end else begin
         state_reg    <= state_next;
         nac_reg      <= nac_next;
         lmd_reg      <= lmd_next;
         untrust_reg  <= untrust_next;
         fail_reg     <= fail_next;
         acc_reg      <= acc_next;
         volt_reg     <= volt_next;
         temp_reg     <= temp_next;
         rate_reg     <= rate_next;
         tte_reg      <= tte_next;
         edv1_reg     <= edv1_next;
         edvf_reg     <= edvf_next;
         deadband_reg <= deadband_next;
         tcomp_reg    <= tcomp_next;
         irq_stat_reg <= irq_stat_next;
         irq_en_reg   <= irq_en_next;
      end
   end

   // ************************************************************
   // AXI4-Lite slave
   // ************************************************************
   logic        aw_held_reg, aw_held_next;
   logic        w_held_reg, w_held_next;
   logic [7:0]  aw_addr_reg, aw_addr_next;
   logic [31:0] w_data_reg, w_data_next;
   logic        bvalid_reg, bvalid_next;
   logic [1:0]  bresp_reg, bresp_next;
   logic        rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0]  rresp_reg, rresp_next;
   logic        wr_known;

   assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
   assign S_AXI_WREADY  = !w_held_reg && !bvalid_reg;
   assign S_AXI_ARREADY = !rvalid_reg;
   assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_addr = aw_addr_reg;
   assign wr_data = w_data_reg;

   always_comb begin
      aw_held_next = aw_held_reg;
      w_held_next  = w_held_reg;
      aw_addr_next = aw_addr_reg;
      w_data_next  = w_data_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rdata_next   = rdata_reg;
      rresp_next   = rresp_reg;
      wr_known = (wr_addr == ADDR_CTRL) || (wr_addr == ADDR_RATE) || (wr_addr == ADDR_EDV)
              || (wr_addr == ADDR_DEADBAND) || (wr_addr == ADDR_TCOMP)
              || (wr_addr == ADDR_IRQ_EN) || (wr_addr == ADDR_IRQ_CLR);
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_held_next = 1'b1;
         aw_addr_next = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_held_next = 1'b1;
         w_data_next = S_AXI_WDATA;
      end
      if (wr_fire) begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = wr_known ? RESP_OK : RESP_ERR;
      end else if (bvalid_reg && S_AXI_BREADY) begin
         bvalid_next = 1'b0;
      end
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         rvalid_next = 1'b1;
         rresp_next  = RESP_OK;
         unique case (S_AXI_ARADDR)
            ADDR_STATUS:   rdata_next = {27'h0, fail_reg, edvf_hit, edv1_hit,
                                         state_reg == ST_SLEEP, untrust_reg};
            ADDR_NAC:      rdata_next = {16'h0, nac_reg};
            ADDR_LMD:      rdata_next = {16'h0, lmd_reg};
            ADDR_VOLT:     rdata_next = {16'h0, volt_reg};
            ADDR_TEMP:     rdata_next = {16'h0, temp_reg};
            ADDR_RATE:     rdata_next = {16'h0, rate_reg};
            ADDR_TTE:      rdata_next = {16'h0, tte_reg};
            ADDR_EDV:      rdata_next = {edv1_reg, edvf_reg};
            ADDR_DEADBAND: rdata_next = {24'h0, deadband_reg};
            ADDR_TCOMP:    rdata_next = {24'h0, tcomp_reg};
            ADDR_IRQ_STAT: rdata_next = {28'h0, irq_stat_reg};
            ADDR_IRQ_EN:   rdata_next = {28'h0, irq_en_reg};
            ADDR_ACC:      rdata_next = 32'(acc_reg);
            default: begin
               rdata_next = '0;
               rresp_next = RESP_ERR;
            end
         endcase
      end else if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= '0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OK;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= RESP_OK;
      end else begin
         aw_held_reg <= aw_held_next;
         w_held_reg  <= w_held_next;
         aw_addr_reg <= aw_addr_next;
         w_data_reg  <= w_data_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Backup copies are driven continuously so the retained RAM always mirrors NOMINAL_REMAINING_CAPACITY and LEARNED_FULL_CAPACITY.
   assign NAC_O         = nac_reg;
   assign LMD_O         = lmd_reg;
   assign NAC_DUP_O     = nac_reg[15:8];
   assign LMD_DUP_O     = lmd_reg[15:8];
   assign UNTRUST_O     = untrust_reg;
   assign SLEEP_O       = (state_reg == ST_SLEEP);
   assign IRQ_O         = |(irq_stat_reg & irq_en_reg);
   assign S_AXI_BVALID  = bvalid_reg;
   assign S_AXI_BRESP   = bresp_reg;
   assign S_AXI_RVALID  = rvalid_reg;
   assign S_AXI_RDATA   = rdata_reg;
   assign S_AXI_RRESP   = rresp_reg;

endmodule : bca_core

// [test/bca_core_chk.sv]
// Concurrent checks on the ports of the charge accumulator core.
`timescale 1ns/1ns
module bca_core_chk import bca_pkg::*; #(
   parameter logic [15:0] LMD_DEFAULT = 16'h2000
) (
   input wire logic        CLK_SYS_I,
   input wire logic        RST_N_I,
   input wire logic        HOST_LINE_I,
   input wire logic [7:0]  BACKUP_CHK_A_I,
   input wire bca_vfc_s    VFC_I,
   input wire logic [15:0] NAC_O,
   input wire logic [15:0] LMD_O,
   input wire logic [7:0]  NAC_DUP_O,
   input wire logic [7:0]  LMD_DUP_O,
   input wire logic        UNTRUST_O,
   input wire logic        SLEEP_O,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY
);
   // ************************************************************
   // Sequences and properties
   // ************************************************************
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_line_low; !HOST_LINE_I [*4]; endsequence
   sequence s_check_bad; $rose(RST_N_I) && BACKUP_CHK_A_I != CHECK_A; endsequence
   sequence s_wr_taken; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY; endsequence

   // The line passes a two-stage synchroniser, so a few cycles of lag are allowed.
   property p_sleep_entry;
      s_line_low |-> ##[0:6] SLEEP_O;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
   property p_check_fail;
      s_check_bad |-> ##[1:3] (NAC_O == 16'h0000 && LMD_O == LMD_DEFAULT && UNTRUST_O);
   endproperty
   a_check_fail: assert property (p_check_fail) else $error("bad backup kept");
   property p_dup_copy;
      $stable(NAC_O) && $stable(LMD_O) |-> NAC_DUP_O == NAC_O[15:8] && LMD_DUP_O == LMD_O[15:8];
   endproperty
   a_dup_copy: assert property (p_dup_copy) else $error("duplicate byte differs");
   property p_untrust_sticky;
      !UNTRUST_O |=> !UNTRUST_O;
   endproperty
   a_untrust_sticky: assert property (p_untrust_sticky) else $error("flag set again");
   // Quiet cycles before the pulse keep an earlier charge pulse out of the window.
   property p_disch_no_rise;
      VFC_I.pulse && VFC_I.discharge && !$past(VFC_I.pulse) && !$past(VFC_I.pulse, 2)
         && $past(RST_N_I) |=> NAC_O <= $past(NAC_O);
   endproperty
   a_disch_no_rise: assert property (p_disch_no_rise) else $error("capacity rose");
   property p_wr_answer;
      s_wr_taken |-> ##2 S_AXI_BVALID;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write response late");
   property p_rd_answer;
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read data late");
   property p_b_done;
      S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
   endproperty
   a_b_done: assert property (p_b_done) else $error("write response repeated");
   property p_r_done;
      S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
   endproperty
   a_r_done: assert property (p_r_done) else $error("read data repeated");
endmodule : bca_core_chk

// [test/bca_host_model.sv]
// Behavioural host controller as seen on the single-wire line.
`timescale 1ns/1ns
module bca_host_model (
   input  wire logic clk_i,
   input  wire logic powered_i,
   output logic      line_o
);
   // ************************************************************
   // Line level
   // ************************************************************
   initial line_o = 1'b1;
   // An unpowered host lets the internal pull-down win, so the line reads low.
   always @(posedge clk_i) begin
      line_o <= powered_i;
   end
endmodule : bca_host_model

// [test/bca_core_bench.sv]
// Self-checking testbench for the charge accumulator core.
`timescale 1ns/1ns
module bca_core_bench import bca_pkg::*;;
   localparam logic [15:0] LMD_DFLT = 16'h2000;
   logic        CLK_SYS_I, RST_N_I, HOST_LINE_I, RBI_OK_I, BACKUP_UNTRUST_I, host_on;
   logic [15:0] BACKUP_NAC_I, BACKUP_LMD_I, NAC_O, LMD_O, n0;
   logic [7:0]  BACKUP_CHK_A_I, BACKUP_CHK_B_I, VFC_OFFSET_I, NV_DEADBAND_I, NAC_DUP_O, LMD_DUP_O;
   logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
   logic [3:0]  S_AXI_WSTRB;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
   logic        UNTRUST_O, SLEEP_O, IRQ_O, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
   logic        S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
   logic        S_AXI_RVALID, S_AXI_RREADY;
   bca_vfc_s    VFC_I;
   bca_adc_s    ADC_I;
   int          fail_count = 0, checks_done = 0, cyc = 0;

   bca_core #(.LMD_DEFAULT(LMD_DFLT)) dut (
      .CLK_SYS_I, .RST_N_I, .HOST_LINE_I, .RBI_OK_I, .BACKUP_NAC_I, .BACKUP_LMD_I,
      .BACKUP_NAC_DUP_I(BACKUP_NAC_I[15:8]), .BACKUP_LMD_DUP_I(BACKUP_LMD_I[15:8]),
      .BACKUP_CHK_A_I, .BACKUP_CHK_B_I, .BACKUP_UNTRUST_I, .VFC_I, .VFC_OFFSET_I, .ADC_I,
      .NV_DEADBAND_I, .NAC_O, .LMD_O, .NAC_DUP_O, .LMD_DUP_O, .UNTRUST_O, .SLEEP_O, .IRQ_O,
      .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
      .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
      .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY
   );
   bca_host_model host (.clk_i(CLK_SYS_I), .powered_i(host_on), .line_o(HOST_LINE_I));

   // ************************************************************
   // Tasks
   // ************************************************************
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task final_report;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   task do_reset;
      RST_N_I <= 1'b0;
      repeat (4) @(posedge CLK_SYS_I);
      RST_N_I <= 1'b1;
      repeat (4) @(posedge CLK_SYS_I);
   endtask : do_reset

   // The trailing edges let registered outputs settle before the caller looks.
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_SYS_I);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do begin
         @(posedge CLK_SYS_I);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (!S_AXI_BVALID);
      S_AXI_BREADY <= 1'b0;
      chk("bresp", S_AXI_BRESP, (a > ADDR_TCOMP) ? RESP_ERR : RESP_OK);
      repeat (2) @(posedge CLK_SYS_I);
   endtask : wr

   task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge CLK_SYS_I);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do begin
         @(posedge CLK_SYS_I);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (!S_AXI_RVALID);
      S_AXI_RREADY <= 1'b0;
      chk(nm, S_AXI_RDATA & m, e);
      chk("rresp", S_AXI_RRESP, (a > ADDR_TCOMP) ? RESP_ERR : RESP_OK);
   endtask : rdc

   task pulse(input logic dis, input logic [7:0] mag);
      n0 = NAC_O;
      VFC_I <= '{1'b1, dis, mag};
      @(posedge CLK_SYS_I);
      VFC_I <= '0;
      repeat (6) @(posedge CLK_SYS_I);
   endtask : pulse

   // ************************************************************
   // Stimulus
   // ************************************************************
   initial begin
      CLK_SYS_I = 1'b0;
      forever #2 CLK_SYS_I = ~CLK_SYS_I;
   end

   always @(posedge CLK_SYS_I) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         final_report();
      end
   end

   initial begin
      {RST_N_I, RBI_OK_I, BACKUP_UNTRUST_I, host_on} = 4'b0101;
      {BACKUP_NAC_I, BACKUP_LMD_I, BACKUP_CHK_A_I, BACKUP_CHK_B_I} = 48'h0100_0400_5a_a5;
      {VFC_OFFSET_I, NV_DEADBAND_I, S_AXI_WSTRB} = 20'h04_00_f;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'b0;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, VFC_I, ADC_I} = '0;
      do_reset();
      chk("nac_kept", NAC_O, 16'h0100);
      chk("lmd_kept", LMD_O, 16'h0400);
      chk("untrust_kept", UNTRUST_O, 1'b0);
      chk("dups", {NAC_DUP_O, LMD_DUP_O}, 16'h0104);
      rdc("edv_init", ADDR_EDV, 32'hffffffff, 32'h0cb20bb8);
      rdc("irq_en_init", ADDR_IRQ_EN, 32'hf, 32'h0);
      wr(ADDR_RATE, 32'h0);
      rdc("tte_zero_rate", ADDR_TTE, 32'hffff, 32'hffff);
      wr(ADDR_RATE, 32'h10);
      rdc("tte", ADDR_TTE, 32'hffff, 32'h03c0);
      pulse(1'b0, 8'h20);
      chk("nac_up", NAC_O, 16'h011c);
      pulse(1'b1, 8'h20);
      chk("nac_down", NAC_O, 16'h0100);
      wr(ADDR_DEADBAND, 32'h40);
      pulse(1'b1, 8'h43);
      chk("db_drop", NAC_O, n0);
      pulse(1'b1, 8'h44);
      chk("db_edge", NAC_O, 16'h00c0);
      ADC_I <= '{1'b1, 16'h0c10, 16'h0b80, 16'h0010, 16'h0008};
      @(posedge CLK_SYS_I);
      ADC_I.valid <= 1'b0;
      rdc("volt", ADDR_VOLT, 32'hffff, 32'h0c00);
      rdc("temp", ADDR_TEMP, 32'hffff, 32'h0b78);
      rdc("edv_flags", ADDR_STATUS, 32'hc, 32'h4);
      rdc("irq_stat", ADDR_IRQ_STAT, 32'hf, 32'h1);
      chk("irq_masked", IRQ_O, 1'b0);
      wr(ADDR_IRQ_EN, 32'hf);
      chk("irq_on", IRQ_O, 1'b1);
      wr(ADDR_IRQ_CLR, 32'h1);
      chk("irq_off", IRQ_O, 1'b0);
      rdc("unmapped", 8'h3c, 32'hffffffff, 32'h0);
      wr(8'h3c, 32'h1);
      host_on <= 1'b0;
      for (int i = 0; i < 20 && SLEEP_O !== 1'b1; i++) @(posedge CLK_SYS_I);
      chk("sleep", SLEEP_O, 1'b1);
      rdc("sleep_irq", ADDR_IRQ_STAT, 32'h4, 32'h4);
      host_on <= 1'b1;
      BACKUP_CHK_A_I <= 8'h00;
      do_reset();
      chk("nac_clr", NAC_O, 16'h0);
      chk("lmd_reload", LMD_O, LMD_DFLT);
      chk("untrust_set", UNTRUST_O, 1'b1);
      rdc("corrupt", ADDR_STATUS, 32'h11, 32'h11);
      rdc("db_init", ADDR_DEADBAND, 32'hff, 32'h0);
      rdc("rate_init", ADDR_RATE, 32'hffff, 32'h0);
      ADC_I <= '{1'b1, 16'h0c10, 16'h0b80, 16'h0010, 16'h0008};
      @(posedge CLK_SYS_I);
      ADC_I.valid <= 1'b0;
      wr(ADDR_CTRL, 32'h1);
      chk("untrust_clr", UNTRUST_O, 1'b0);
      final_report();
   end
endmodule : bca_core_bench

bind bca_core bca_core_chk #(.LMD_DEFAULT(LMD_DEFAULT)) u_chk (
   .CLK_SYS_I, .RST_N_I, .HOST_LINE_I, .BACKUP_CHK_A_I, .VFC_I, .NAC_O, .LMD_O, .NAC_DUP_O,
   .LMD_DUP_O, .UNTRUST_O, .SLEEP_O, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
   .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
   .S_AXI_RVALID, .S_AXI_RREADY
);
